// ===== stepper_defs.svh
// Offsets, field positions, reset values and timing counts of the stepper bridge block.
// Assumes a 100 MHz clock and byte addresses on the register bus.
`ifndef STEPPER_DEFS_SVH
`define STEPPER_DEFS_SVH
`define CMD_OFS 8'h00
`define POS_HIGH_OFS 8'h04
`define POS_LOW_OFS 8'h08
`define FAULT_ONE_OFS 8'h0c
`define FAULT_TWO_OFS 8'h10
`define STATUS_OFS 8'h14
`define CMD_EN_BIT 0
`define CMD_DIR_BIT 1
`define CMD_STEP_BIT 2
`define CMD_SWRST_BIT 3
`define POS_RESET 10'h200
`define POS_MAX 10'h3ff
`define POS_MIN 10'h000
`define CLK_NS 10
`define MASK_MS 1
`define OFF_DEGLITCH_US 125
`define ON_FILTER_US 10
`define OL_FILTER_US 20
`define MASK_CYC ((`MASK_MS * 1000000 + `CLK_NS - 1) / `CLK_NS)
`define OFF_DEGLITCH_CYC ((`OFF_DEGLITCH_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define ON_FILTER_CYC ((`ON_FILTER_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define OL_FILTER_CYC ((`OL_FILTER_US * 1000 + `CLK_NS - 1) / `CLK_NS)
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== stepper_pkg.sv
// Types shared by the stepper bridge block and its bench.
// Assumes nothing beyond the defs header.
package stepper_pkg;
	// Fault codes of one bridge fault register.
	typedef enum logic [2:0] {
		FLT_NONE = 3'b000,
		FLT_SHORT_GND = 3'b001,
		FLT_SHORT_BAT = 3'b010,
		FLT_OPEN_OFF = 3'b011,
		FLT_DET_RUN = 3'b100,
		FLT_OPEN_ON = 3'b101,
		FLT_OVERCUR = 3'b110
	} fault_e;
	// Comparator levels of one bridge.
	typedef struct packed {
		logic short_to_ground;
		logic short_to_battery;
		logic open_load;
		logic overcurrent;
		logic below_open_load;
	} sense_s;
	typedef sense_s [1:0] sense_pair_t;
endpackage

// ===== stepper_bridge_counter_diag.sv
// Stepper sequencer, saturating position counter and two-bridge diagnosis.
// Assumes an AXI4-Lite master on aclk and asynchronous comparator levels.
//
// What this block does
// - Ten-bit position counter, high and low five bits in separate registers.
// - Position counter starts at 512 after power-up.
// - Direction one: each performed step adds one to the position.
// - Direction zero: each performed step subtracts one from the position.
// - Counter saturates at its ends and resumes after reversing direction or a reset.
// - Both position registers carry a two-bit tag identifying the same step.
// - Power-on reset and software reset both restore the initial position.
// - Bridge fault registers clear when a read of them begins.
// - One summary bit is set while any output holds a fault.
// - Off state: mask 1 ms, then faults lasting over 125 us latch.
// - On-state faults replace off-state faults; overcurrent beats off faults.
// - A latched off-state fault never blocks switching the bridges on.
// - Bridges off through an invalid command skip off-state diagnosis.
// - Overcurrent over 10 us switches bridge off until a new command.
// - Each bridge reports its faults in its own fault register.
// - On state: current below threshold over 20 us flags open load.
// - Unresolved fault shows detection running, resolved at the next step.
// - Detection running and open load latch at low-side edges, else drop.
// - Reading a fault register clears detection running and restarts the open-load filter.
// - With enable set, only a zero-to-one step write advances the sequence.
// - Power-on phase drives outputs 21, 24 and 26, 27.
`timescale 1ns/1ps
`default_nettype none
`include "stepper_defs.svh"
module stepper_bridge_counter_diag #(
	parameter int MASK_CYC = `MASK_CYC,
	parameter int OFF_DEGLITCH_CYC = `OFF_DEGLITCH_CYC
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels.
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read channels.
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Comparator levels from both bridges.
	input wire stepper_pkg::sense_pair_t sense,
	// Driver commands, bit 0 is output 21 up to bit 7 output 28.
	output logic [7:0] bridge_drive,
	output logic any_output_fault_flag
);
	import stepper_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		logic [16:0] mask_cnt;
		logic [16:0] flt_cnt;
		logic [16:0] oc_cnt;
		logic [16:0] ol_cnt;
		logic oc_trip;
		logic ol_pend;
		fault_e code;
	} bridge_s;

	typedef struct packed {
		sense_pair_t sync1;
		sense_pair_t sync2;
		logic en;
		logic dir;
		logic step;
		logic inval;
		logic [1:0] phase;
		logic [9:0] pos;
		logic [1:0] tag;
		bridge_s [1:0] br;
		logic [7:0] drive;
		logic aw_got;
		logic w_got;
		logic [7:0] wa;
		logic [31:0] wd;
		logic wen;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} state_s;

	localparam logic [16:0] MASK_N = 17'(MASK_CYC);
	localparam logic [16:0] DEGL_N = 17'(OFF_DEGLITCH_CYC);
	localparam logic [16:0] ONF_N = 17'(`ON_FILTER_CYC);
	localparam logic [16:0] OLF_N = 17'(`OL_FILTER_CYC);

	state_s state_reg;
	state_s state_next;

	////////////////////////////////////////////////////////////////////////
	// Per-bridge diagnosis step.

	// Advances one bridge by a cycle; a read clear is applied before new sets.
	function automatic bridge_s bridge_step(
		input bridge_s b,
		input sense_s s,
		input logic on,
		input logic off_diag,
		input logic edge_ev,
		input logic rd_clr,
		input logic oc_clr
	);
		bridge_s n;
		logic off_flt;
		n = b;
		off_flt = s.short_to_ground | s.short_to_battery | s.open_load;
		if (rd_clr) begin
			n.code = FLT_NONE;
			n.ol_cnt = 17'h0;
			n.ol_pend = 1'b0;
		end
		if (oc_clr) begin
			n.oc_trip = 1'b0;
		end
		// Off-state mask and deglitch, held idle while driven or inhibited.
		if (!off_diag) begin
			n.mask_cnt = 17'h0;
			n.flt_cnt = 17'h0;
		end else if (b.mask_cnt < MASK_N) begin
			n.mask_cnt = b.mask_cnt + 17'h1;
		end else if (!off_flt) begin
			n.flt_cnt = 17'h0;
		end else if (b.flt_cnt < DEGL_N) begin
			n.flt_cnt = b.flt_cnt + 17'h1;
		end else if (n.code == FLT_NONE) begin
			// First off fault latches; ground beats battery beats open.
			if (s.short_to_ground) begin
				n.code = FLT_SHORT_GND;
			end else if (s.short_to_battery) begin
				n.code = FLT_SHORT_BAT;
			end else begin
				n.code = FLT_OPEN_OFF;
			end
		end
		// On-state overcurrent filter.
		if (on && s.overcurrent) begin
			if (b.oc_cnt < ONF_N) begin
				n.oc_cnt = b.oc_cnt + 17'h1;
			end else begin
				n.oc_trip = 1'b1;
				n.code = FLT_OVERCUR;
			end
		end else begin
			n.oc_cnt = 17'h0;
		end
		// On-state low current filter.
		if (!rd_clr) begin
			if (on && s.below_open_load) begin
				if (b.ol_cnt < OLF_N) begin
					n.ol_cnt = b.ol_cnt + 17'h1;
				end else begin
					n.ol_pend = 1'b1;
				end
			end else begin
				n.ol_cnt = 17'h0;
				n.ol_pend = 1'b0;
			end
		end
		// Low-side edge: latch, resolve or drop the open-load indication.
		if (edge_ev && n.code != FLT_OVERCUR) begin
			if (b.ol_pend) begin
				if (n.code == FLT_DET_RUN) begin
					n.code = FLT_OPEN_ON;
				end else begin
					n.code = FLT_DET_RUN;
				end
			end else if (n.code == FLT_DET_RUN || n.code == FLT_OPEN_ON) begin
				n.code = FLT_NONE;
			end
		end
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	// Bus handshakes, command decode, sequencer, counter and diagnosis.
	always_comb begin
		logic aw_now;
		logic w_now;
		logic [7:0] ra;
		logic [31:0] cmd;
		logic cmd_wr;
		logic cmd_ok;
		logic adv;
		logic oc_clr;
		logic [1:0] rclr;
		logic on;
		state_next = state_reg;
		aw_now = 1'b0;
		w_now = 1'b0;
		ra = araddr;
		cmd = 32'h0;
		cmd_wr = 1'b0;
		cmd_ok = 1'b0;
		adv = 1'b0;
		oc_clr = 1'b0;
		rclr = 2'b00;
		on = 1'b0;
		// Two-stage synchronisers on the comparator levels.
		state_next.sync1 = sense;
		state_next.sync2 = state_reg.sync1;
		// Write address and data are taken in either order.
		if (awvalid && awready) begin
			state_next.aw_got = 1'b1;
			state_next.wa = awaddr;
		end
		if (wvalid && wready) begin
			state_next.w_got = 1'b1;
			state_next.wd = wdata;
			state_next.wen = wstrb[0];
		end
		aw_now = state_reg.aw_got;
		w_now = state_reg.w_got;
		if (aw_now && w_now) begin
			state_next.aw_got = 1'b0;
			state_next.w_got = 1'b0;
			state_next.bvalid = 1'b1;
			if (state_reg.wa == `CMD_OFS) begin
				state_next.bresp = `RESP_OKAY;
				cmd_wr = state_reg.wen;
				cmd = state_reg.wd;
			end else if (state_reg.wa == `POS_HIGH_OFS || state_reg.wa == `POS_LOW_OFS ||
				state_reg.wa == `FAULT_ONE_OFS || state_reg.wa == `FAULT_TWO_OFS ||
				state_reg.wa == `STATUS_OFS) begin
				state_next.bresp = `RESP_OKAY;
			end else begin
				state_next.bresp = `RESP_SLVERR;
			end
		end
		if (state_reg.bvalid && bready) begin
			state_next.bvalid = 1'b0;
		end
		// Command write: reserved bits set make the command invalid.
		if (cmd_wr) begin
			cmd_ok = (cmd[7:4] == 4'h0);
			if (!cmd_ok) begin
				state_next.en = 1'b0;
				state_next.inval = 1'b1;
				state_next.step = 1'b0;
			end else begin
				state_next.inval = 1'b0;
				state_next.en = cmd[`CMD_EN_BIT];
				state_next.dir = cmd[`CMD_DIR_BIT];
				// Enable and step written together while enable is low counts as enable alone.
				state_next.step = state_reg.en & cmd[`CMD_STEP_BIT];
				adv = state_reg.en & cmd[`CMD_EN_BIT] & ~state_reg.step & cmd[`CMD_STEP_BIT];
				oc_clr = cmd[`CMD_EN_BIT];
			end
		end
		// A performed step moves the phase and the counter in the old direction.
		if (adv) begin
			state_next.tag = state_reg.tag + 2'h1;
			if (state_reg.dir) begin
				state_next.phase = state_reg.phase + 2'h1;
				if (state_reg.pos != `POS_MAX) begin
					state_next.pos = state_reg.pos + 10'h1;
				end
			end else begin
				state_next.phase = state_reg.phase - 2'h1;
				if (state_reg.pos != `POS_MIN) begin
					state_next.pos = state_reg.pos - 10'h1;
				end
			end
		end
		if (cmd_wr && cmd_ok && cmd[`CMD_SWRST_BIT]) begin
			state_next.pos = `POS_RESET;
			state_next.tag = 2'h0;
			state_next.phase = 2'h0;
		end
		// Read is answered one cycle after the address is taken.
		if (arvalid && arready) begin
			state_next.rvalid = 1'b1;
			state_next.rresp = `RESP_OKAY;
			if (ra == `CMD_OFS) begin
				state_next.rdata = {29'h0, state_reg.step, state_reg.dir, state_reg.en};
			end else if (ra == `POS_HIGH_OFS) begin
				state_next.rdata = {25'h0, state_reg.tag, state_reg.pos[9:5]};
			end else if (ra == `POS_LOW_OFS) begin
				state_next.rdata = {25'h0, state_reg.tag, state_reg.pos[4:0]};
			end else if (ra == `FAULT_ONE_OFS) begin
				state_next.rdata = {29'h0, state_reg.br[0].code};
				rclr[0] = 1'b1;
			end else if (ra == `FAULT_TWO_OFS) begin
				state_next.rdata = {29'h0, state_reg.br[1].code};
				rclr[1] = 1'b1;
			end else if (ra == `STATUS_OFS) begin
				state_next.rdata = {22'h0, state_reg.drive, state_reg.inval, any_output_fault_flag};
			end else begin
				state_next.rdata = 32'h0;
				state_next.rresp = `RESP_SLVERR;
			end
		end else if (state_reg.rvalid && rready) begin
			state_next.rvalid = 1'b0;
		end
		// Per-bridge diagnosis and drive pattern.
		for (int i = 0; i < 2; i++) begin
			on = state_reg.en & ~state_reg.br[i].oc_trip;
			state_next.br[i] = bridge_step(state_reg.br[i], state_reg.sync2[i], on,
				~on & ~state_reg.inval, adv, rclr[i], oc_clr);
		end
		// Drive follows the next phase; a tripped bridge drives nothing.
		state_next.drive = 8'h00;
		if (state_next.en && !state_next.br[0].oc_trip) begin
			if (state_next.phase[1] == 1'b0) begin
				state_next.drive[0] = 1'b1;
				state_next.drive[3] = 1'b1;
			end else begin
				state_next.drive[2] = 1'b1;
				state_next.drive[1] = 1'b1;
			end
		end
		if (state_next.en && !state_next.br[1].oc_trip) begin
			if (state_next.phase == 2'h0 || state_next.phase == 2'h3) begin
				state_next.drive[5] = 1'b1;
				state_next.drive[6] = 1'b1;
			end else begin
				state_next.drive[4] = 1'b1;
				state_next.drive[7] = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register.

	// Synchronous reset puts the power-up values in place.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= '0;
			state_reg.pos <= `POS_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs.

	// Handshakes come from state; data from flip-flops.
	assign awready = ~state_reg.aw_got & ~state_reg.bvalid;
	assign wready = ~state_reg.w_got & ~state_reg.bvalid;
	assign bvalid = state_reg.bvalid;
	assign bresp = state_reg.bresp;
	assign arready = ~state_reg.rvalid;
	assign rvalid = state_reg.rvalid;
	assign rresp = state_reg.rresp;
	assign rdata = state_reg.rdata;
	assign bridge_drive = state_reg.drive;
	// Summary fault bit across both bridges.
	assign any_output_fault_flag = (state_reg.br[0].code != FLT_NONE) |
		(state_reg.br[1].code != FLT_NONE);
endmodule // stepper_bridge_counter_diag
`default_nettype wire

// ===== mcu_model.sv
// Microcontroller model: AXI4-Lite master that drives the stepper block.
// Assumes one caller at a time; ready is sampled mid-cycle, where it is settled.
// Responses are accepted one cycle after they appear, so the slave must hold them.
`timescale 1ns/1ps
`default_nettype none
module mcu_model (
	// Clock.
	input wire logic aclk,
	// Write channels.
	output logic [7:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// Read channels.
	output logic [7:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	// The bus is idle at time zero.
	initial begin
		{awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
	end
	////////////////
	// Address and data go out together; each is dropped at the edge that takes it.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ha, hw, hb;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			@(posedge aclk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
		end while ((awvalid && !ha) || (wvalid && !hw));
		do begin
			@(negedge aclk);
			hb = bvalid;
			@(posedge aclk);
		end while (!hb);
		bready <= 1'b1;
		@(negedge aclk);
		r = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask
	// Read: the address is held until taken, the data is taken with rvalid.
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic h;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			h = arready;
			@(posedge aclk);
		end while (!h);
		arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			h = rvalid;
			@(posedge aclk);
		end while (!h);
		rready <= 1'b1;
		@(negedge aclk);
		d = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask
endmodule // mcu_model
`default_nettype wire

// ===== stepper_properties.sv
// Checker of the stepper block's bus handshakes and bridge drive.
// Assumes the top module's port names; bound at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
`include "stepper_defs.svh"
module stepper_properties (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Bus signals.
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	// Drive outputs.
	input wire logic [7:0] bridge_drive
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	////////////////
	// Address and data of a write taken at one edge.
	sequence s_wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	// Responses stand until taken, and nothing new is accepted meanwhile.
	a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read response dropped");
	a_write_refused: assert property (bvalid |-> !awready && !wready)
		else $error("write taken during response");
	a_read_refused: assert property (rvalid |-> !arready)
		else $error("read taken during response");
	a_write_answer: assert property (s_wr_taken |-> ##2 bvalid)
		else $error("write response late");
	a_read_answer: assert property (arvalid && arready |=> rvalid)
		else $error("read response late");
	a_unmapped_err: assert property (arvalid && arready && araddr > `STATUS_OFS |=> rresp == `RESP_SLVERR && rdata == 32'h0)
		else $error("unmapped read not refused");
	// Drive shape and its causes.
	a_drive_legal: assert property ((bridge_drive[3:0] inside {4'h0, 4'h6, 4'h9}) && (bridge_drive[7:4] inside {4'h0, 4'h6, 4'h9}))
		else $error("illegal bridge pattern");
	a_drive_cause: assert property ($changed(bridge_drive) |-> $rose(bvalid) || bridge_drive[3:0] == 4'h0 || bridge_drive[7:4] == 4'h0)
		else $error("drive moved without a command");
	a_reset_idle: assert property ($rose(aresetn) |-> bridge_drive == 8'h00 && !bvalid && !rvalid)
		else $error("outputs not idle after reset");
endmodule // stepper_properties
bind stepper_bridge_counter_diag stepper_properties u_stepper_properties (.*);
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench of the stepper block: counter, drive sequence and diagnosis.
// Assumes the microcontroller model and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none
`include "stepper_defs.svh"
module tb_top;
	import stepper_pkg::*;
	typedef struct packed {logic [7:0] a; logic [1:0] r; logic [31:0] d;} row_s;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, any_output_fault_flag;
	logic [7:0] awaddr, araddr, bridge_drive;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	sense_pair_t sense;
	int err_total = 0;
	int n_checks = 0;
	int cycles = 0;
	row_s rows [7] = '{'{`CMD_OFS, `RESP_OKAY, 32'h0}, '{`POS_HIGH_OFS, `RESP_OKAY, 32'h10},
		'{`POS_LOW_OFS, `RESP_OKAY, 32'h0}, '{`FAULT_ONE_OFS, `RESP_OKAY, 32'h0},
		'{`FAULT_TWO_OFS, `RESP_OKAY, 32'h0}, '{`STATUS_OFS, `RESP_OKAY, 32'h0}, '{8'h18, `RESP_SLVERR, 32'h0}};
	stepper_bridge_counter_diag #(.MASK_CYC(20), .OFF_DEGLITCH_CYC(10)) u_stepper_bridge_counter_diag (.aclk, .aresetn,
		.awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
		.arready, .rdata, .rresp, .rvalid, .rready, .sense, .bridge_drive, .any_output_fault_flag);
	mcu_model u_mcu_model (.*);
	////////////////
	// Clock, and a ceiling on the run length.
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			err_total++;
			results();
		end
	end
	// Comparison and bus helpers.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		u_mcu_model.rd(a, d, r);
		chk(d, e);
	endtask
	task automatic wrc(input logic [31:0] v);
		u_mcu_model.wr(`CMD_OFS, v, r);
		chk({30'h0, r}, {30'h0, `RESP_OKAY});
	endtask
	task automatic pos(input logic [9:0] p, input logic [1:0] t);
		rdc(`POS_HIGH_OFS, {25'h0, t, p[9:5]});
		rdc(`POS_LOW_OFS, {25'h0, t, p[4:0]});
	endtask
	// One step is a write with the step bit low, then one with it high.
	task automatic step(input logic dr, input int n);
		repeat (n) begin
			wrc({29'h0, 1'b0, dr, 1'b1});
			wrc({29'h0, 1'b1, dr, 1'b1});
		end
	endtask
	task automatic drv(input logic [7:0] e);
		#1;
		chk({24'h0, bridge_drive}, {24'h0, e});
	endtask
	task automatic flg(input logic e);
		#1;
		chk({31'h0, any_output_fault_flag}, {31'h0, e});
	endtask
	task automatic sn(input int b, input logic [4:0] v);
		@(posedge aclk);
		sense[b] <= v;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic results;
		if (err_total == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	////////////////
	// Reset, register table, then the hand-written cases.
	initial begin
		aresetn = 1'b0;
		sense = '0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i]) begin
			u_mcu_model.rd(rows[i].a, d, r);
			chk(d, rows[i].d);
			chk({30'h0, r}, {30'h0, rows[i].r});
		end
		// A write to a read-only position register is answered and ignored.
		u_mcu_model.wr(`POS_HIGH_OFS, 32'h1f, r);
		chk({30'h0, r}, {30'h0, `RESP_OKAY});
		u_mcu_model.wr(8'h18, 32'h0, r);
		chk({30'h0, r}, {30'h0, `RESP_SLVERR});
		wrc(32'h3);
		drv(8'h69);
		rdc(`STATUS_OFS, 32'h1a4);
		wrc(32'h7);
		drv(8'h99);
		pos(10'd513, 2'd1);
		wrc(32'h3);
		drv(8'h99);
		step(1'b0, 1);
		drv(8'h69);
		pos(10'd512, 2'd2);
		step(1'b0, 514);
		pos(10'd0, 2'd0);
		step(1'b1, 1025);
		pos(10'd1023, 2'd1);
		step(1'b0, 1);
		pos(10'd1022, 2'd2);
		wrc(32'h9);
		drv(8'h69);
		pos(10'd512, 2'd0);
		sn(0, 5'h10);
		wrc(32'h10);
		drv(8'h00);
		rdc(`STATUS_OFS, 32'h2);
		cyc(60);
		rdc(`FAULT_ONE_OFS, 32'h0);
		sn(0, 5'h00);
		// Enable is already low; this valid write clears the invalid state, and the modelled comparators carry no residual motor motion to settle.
		wrc(32'h0);
		cyc(40);
		sn(0, 5'h10);
		cyc(4);
		sn(0, 5'h00);
		cyc(20);
		rdc(`FAULT_ONE_OFS, 32'h0);
		sn(0, 5'h10);
		cyc(40);
		flg(1'b1);
		sn(0, 5'h00);
		cyc(4);
		rdc(`FAULT_ONE_OFS, {29'h0, FLT_SHORT_GND});
		rdc(`FAULT_TWO_OFS, 32'h0);
		rdc(`FAULT_ONE_OFS, 32'h0);
		flg(1'b0);
		sn(0, 5'h08);
		cyc(40);
		flg(1'b1);
		sn(0, 5'h00);
		wrc(32'h1);
		drv(8'h69);
		sn(0, 5'h02);
		cyc(990);
		drv(8'h69);
		cyc(20);
		drv(8'h60);
		sn(0, 5'h00);
		cyc(10);
		drv(8'h60);
		rdc(`FAULT_ONE_OFS, {29'h0, FLT_OVERCUR});
		wrc(32'h1);
		drv(8'h69);
		sn(1, 5'h01);
		cyc(2010);
		step(1'b1, 1);
		flg(1'b1);
		cyc(2010);
		step(1'b1, 1);
		rdc(`FAULT_TWO_OFS, {29'h0, FLT_OPEN_ON});
		cyc(2010);
		step(1'b1, 1);
		sn(1, 5'h00);
		cyc(10);
		step(1'b1, 1);
		rdc(`FAULT_TWO_OFS, 32'h0);
		// A read of detection running clears it and the filter starts over.
		sn(1, 5'h01);
		cyc(2010);
		step(1'b1, 1);
		rdc(`FAULT_TWO_OFS, {29'h0, FLT_DET_RUN});
		cyc(2010);
		step(1'b1, 1);
		rdc(`FAULT_TWO_OFS, {29'h0, FLT_DET_RUN});
		// A second reset in mid-run restores the power-up position and idle drive.
		@(posedge aclk);
		aresetn <= 1'b0;
		cyc(2);
		aresetn <= 1'b1;
		pos(10'd512, 2'd0);
		drv(8'h00);
		results();
	end
endmodule // tb_top
`default_nettype wire
